// ===== core/valve_seq.sv
/*
 * valve_seq - isolation valve sequencer top.
 * Assumes synchronous inputs on one 20 MHz clock and a word register port
 * with read data one cycle after the read strobe.
 */
// Contract
// - travel time limits valve stroke
// - unconfirmed position after travel time faults; disabled mode does not supervise
// - selector mode acts only in hand/auto
// - selector mode closes valve in off
// - selector-independent option ignores selector
// - selector option only in independent mode
// - fault override off closes on fault
// - fault override on keeps evaluating
// - fault option only in independent mode
// - open from four sources, all/any
// - unused sources excluded from combination
// - all-met needs every used source
// - any-met needs one used source
// - close wins over open; pump sequence ignores close_req_i
// - pump sequence: open pre-run, close post-run
// - analog compare at or above/below setpoint
// - digital source met while input active
`timescale 1ns/1ps
`default_nettype none
`include "valve_seq_map.svh"

module valve_seq (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // process and system
    input wire logic [159:0] analog_i,
    input wire logic [3:0] digital_i,
    input wire logic close_req_i,
    input wire logic [1:0] hand_off_auto_selector_i,
    input wire logic shutdown_fault_active_i,
    input wire logic [1:0] pump_phase_i,
    // valve actuator
    input wire logic pos_open_i,
    input wire logic pos_closed_i,
    output logic valve_open_cmd_o,
    output logic valve_fault_o,
    // interrupt
    output logic irq_o
);
    // selector encoding: 0 off, 1 hand, 2 auto
    localparam logic [1:0] SEL_OFF = 2'h0;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] travel_s;
        logic [3:0][20:0] src;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] rdata;
        logic [`VS_TICK_W-1:0] tick_cnt;
        logic [`VS_TIME_W-1:0] ms_cnt;
        logic [`VS_TIME_W-1:0] sec_cnt;
        logic open_cmd;
        logic fault;
        valve_seq_pkg::move_state_t move;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [3:0] used;
    logic [3:0] met;

    // ------------------------------------------------------------------
    // source evaluation
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_src
            valve_src_eval u_eval (
                .sel_i(s_q.src[g][`VS_SRC_SEL_LSB +: 4]),
                .dir_le_i(s_q.src[g][`VS_SRC_DIR_BIT]),
                .setpoint_i(s_q.src[g][`VS_SRC_SP_MSB:0]),
                .analog_i(analog_i),
                .digital_i(digital_i),
                .used_o(used[g]),
                .met_o(met[g])
            );
        end
    endgenerate

    function automatic logic is_addr(input logic [3:0] a,
                                     input logic [3:0] b);
        is_addr = (a == b);
    endfunction : is_addr

    // the source words sit in one contiguous window of the map
    function automatic logic is_src(input logic [3:0] a);
        is_src = (a >= `VS_ADDR_SRC_BASE) && (a <= `VS_ADDR_SRC_LAST);
    endfunction : is_src

    function automatic logic [1:0] src_slot(input logic [3:0] a);
        src_slot = 2'(a - `VS_ADDR_SRC_BASE);
    endfunction : src_slot

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic open_dec;
    logic want_open;
    logic tick;
    logic sec_tick;
    logic confirmed;
    logic [2:0] ev;
    valve_seq_pkg::ctrl_mode_t mode;
    valve_seq_pkg::pump_phase_t phase;

    always_comb begin
        s_d = s_q;
        mode = valve_seq_pkg::ctrl_mode_t'(
            s_q.ctrl[`VS_CTRL_MODE_LSB +: 2]);
        phase = valve_seq_pkg::pump_phase_t'(pump_phase_i);
        ev = 3'h0;

        // combine sources; an all-unused set never opens
        if (s_q.ctrl[`VS_CTRL_COMB_BIT]) begin
            open_dec = |(met & used);
        end else begin
            open_dec = (|used) && ((met | ~used) == 4'hf);
        end

        // the open decision latches; only a close path lowers it, so a
        // source that drops out does not close the valve by itself
        want_open = s_q.open_cmd;
        case (mode)
            valve_seq_pkg::MODE_PUMP_SEQ: begin
                // selector and fault options ignored here
                if (phase == valve_seq_pkg::PUMP_PRE_RUN ||
                    phase == valve_seq_pkg::PUMP_RUNNING) begin
                    want_open = 1'b1;
                end else if (phase == valve_seq_pkg::PUMP_POST_RUN) begin
                    want_open = 1'b0;
                end
            end
            valve_seq_pkg::MODE_INDEPENDENT: begin
                if (close_req_i) begin
                    want_open = 1'b0;
                end else if (open_dec) begin
                    want_open = 1'b1;
                end
                if (!s_q.ctrl[`VS_CTRL_SEL_BIT] &&
                    hand_off_auto_selector_i == SEL_OFF) begin
                    want_open = 1'b0;
                end
                // own fault counts as a fault when override is off
                if (!s_q.ctrl[`VS_CTRL_SDF_BIT] &&
                    (shutdown_fault_active_i || s_q.fault)) begin
                    want_open = 1'b0;
                end
            end
            default: begin
                want_open = 1'b0;
            end
        endcase

        // the timer counts whole seconds from the 1 ms tick: a fault lands
        // one cycle after travel_s seconds, and a zero travel time faults
        // on the cycle after the command
        // 1 ms tick from divider, seconds counted from it
        tick = (s_q.tick_cnt == `VS_TICK_W'(`VS_TICK_CYCLES - 1));
        sec_tick = tick && (s_q.ms_cnt == `VS_TIME_W'(`VS_MS_PER_S - 1));
        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;

        confirmed = s_q.open_cmd ? pos_open_i : pos_closed_i;
        s_d.open_cmd = want_open;

        if (want_open != s_q.open_cmd) begin
            // a new command restarts timing
            s_d.move = want_open ? valve_seq_pkg::MOVE_OPENING
                                 : valve_seq_pkg::MOVE_CLOSING;
            s_d.ms_cnt = '0;
            s_d.sec_cnt = '0;
            s_d.tick_cnt = '0;
            s_d.fault = 1'b0;
        end else begin
            case (s_q.move)
                valve_seq_pkg::MOVE_OPENING,
                valve_seq_pkg::MOVE_CLOSING: begin
                    if (confirmed) begin
                        s_d.move = valve_seq_pkg::MOVE_IDLE;
                        ev[s_q.open_cmd ? `VS_IRQ_OPEN_OK
                                        : `VS_IRQ_CLOSE_OK] = 1'b1;
                    end else if (s_q.sec_cnt >= s_q.travel_s) begin
                        s_d.move = valve_seq_pkg::MOVE_FAILED;
                        s_d.fault = 1'b1;
                        ev[`VS_IRQ_FAULT] = 1'b1;
                    end else if (tick) begin
                        s_d.ms_cnt = sec_tick ? '0 : s_q.ms_cnt + 1'b1;
                        if (sec_tick) begin
                            s_d.sec_cnt = s_q.sec_cnt + 1'b1;
                        end
                    end
                end
                valve_seq_pkg::MOVE_FAILED: begin
                    // a late confirmation clears the fault but raises
                    // no confirmation event
                    if (confirmed) begin
                        s_d.move = valve_seq_pkg::MOVE_IDLE;
                        s_d.fault = 1'b0;
                    end
                end
                default: begin
                    s_d.move = valve_seq_pkg::MOVE_IDLE;
                end
            endcase
        end

        // a disabled valve is not supervised, so no fault may linger
        if (mode == valve_seq_pkg::MODE_DISABLED) begin
            s_d.move = valve_seq_pkg::MOVE_IDLE;
            s_d.fault = 1'b0;
        end

        // --------------------------------------------------------------
        // register port
        // --------------------------------------------------------------
        s_d.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            if (is_addr(reg_addr_i, `VS_ADDR_CTRL)) begin
                s_d.rdata = s_q.ctrl;
            end else if (is_addr(reg_addr_i, `VS_ADDR_TRAVEL)) begin
                s_d.rdata = {16'h0000, s_q.travel_s};
            end else if (is_src(reg_addr_i)) begin
                s_d.rdata = {11'h000, s_q.src[src_slot(reg_addr_i)]};
            end else if (is_addr(reg_addr_i, `VS_ADDR_STATUS)) begin
                s_d.rdata = {26'h000_0000, used != 4'h0, s_q.move,
                             s_q.fault, pos_open_i, pos_closed_i};
            end else if (is_addr(reg_addr_i, `VS_ADDR_IRQ_STAT)) begin
                s_d.rdata = {29'h0000_0000, s_q.irq_stat};
            end else if (is_addr(reg_addr_i, `VS_ADDR_IRQ_MASK)) begin
                s_d.rdata = {29'h0000_0000, s_q.irq_mask};
            end
        end
        // set wins over write-one-to-clear
        s_d.irq_stat = s_q.irq_stat;
        if (reg_wr_i) begin
            if (is_addr(reg_addr_i, `VS_ADDR_CTRL)) begin
                s_d.ctrl = {27'h000_0000, reg_wdata_i[4:0]};
            end else if (is_addr(reg_addr_i, `VS_ADDR_TRAVEL)) begin
                s_d.travel_s = reg_wdata_i[15:0];
            end else if (is_src(reg_addr_i)) begin
                s_d.src[src_slot(reg_addr_i)] = reg_wdata_i[20:0];
            end else if (is_addr(reg_addr_i, `VS_ADDR_IRQ_STAT)) begin
                s_d.irq_stat = s_q.irq_stat & ~reg_wdata_i[2:0];
            end else if (is_addr(reg_addr_i, `VS_ADDR_IRQ_MASK)) begin
                s_d.irq_mask = reg_wdata_i[2:0];
            end
        end
        s_d.irq_stat = s_d.irq_stat | ev;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // constants only; the rest of the struct clears to zero
            s_q <= '0;
            s_q.ctrl <= `VS_CTRL_RST;
            s_q.travel_s <= `VS_TRAVEL_RST_S;
            s_q.move <= valve_seq_pkg::MOVE_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    assign valve_open_cmd_o = s_q.open_cmd;
    assign valve_fault_o = s_q.fault;
    assign irq_o = |(s_q.irq_stat & s_q.irq_mask);

endmodule : valve_seq

`default_nettype wire

// ===== core/valve_seq_map.svh
/*
 * valve_seq_map.svh - register offsets, field positions, reset values and
 * timing constants of the isolation valve sequencer.
 * Assumes a 20 MHz system clock and a word-wide register port.
 */
`ifndef VALVE_SEQ_MAP_SVH
`define VALVE_SEQ_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define VS_ADDR_CTRL 4'h0
`define VS_ADDR_TRAVEL 4'h1
`define VS_ADDR_SRC_BASE 4'h2
`define VS_ADDR_STATUS 4'h6
`define VS_ADDR_IRQ_STAT 4'h7
`define VS_ADDR_IRQ_MASK 4'h8
`define VS_ADDR_SRC_LAST 4'h5

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define VS_CTRL_MODE_LSB 0
`define VS_CTRL_SEL_BIT 2
`define VS_CTRL_SDF_BIT 3
`define VS_CTRL_COMB_BIT 4

// source word: [15:0] setpoint, [19:16] source select, [20] direction
`define VS_SRC_SP_MSB 15
`define VS_SRC_SEL_LSB 16
`define VS_SRC_DIR_BIT 20

// interrupt bits
`define VS_IRQ_FAULT 0
`define VS_IRQ_OPEN_OK 1
`define VS_IRQ_CLOSE_OK 2

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define VS_CTRL_RST 32'h0000_0000
`define VS_TRAVEL_RST_S 16'h001e
`define VS_CLK_HZ 20000000
`define VS_TICK_CYCLES (`VS_CLK_HZ / 1000)
`define VS_TICK_W 15
`define VS_TIME_W 16
`define VS_MS_PER_S 1000

`endif

// ===== core/valve_seq_pkg.sv
/*
 * valve_seq_pkg - types of the isolation valve sequencer.
 * Assumes valve_seq_map.svh supplies all numbers.
 */
`default_nettype none

package valve_seq_pkg;

    typedef enum logic [1:0] {
        MODE_DISABLED,
        MODE_PUMP_SEQ,
        MODE_INDEPENDENT,
        MODE_RSVD
    } ctrl_mode_t;

    typedef enum logic [1:0] {
        PUMP_IDLE,
        PUMP_PRE_RUN,
        PUMP_RUNNING,
        PUMP_POST_RUN
    } pump_phase_t;

    typedef enum logic [1:0] {
        MOVE_IDLE,
        MOVE_OPENING,
        MOVE_CLOSING,
        MOVE_FAILED
    } move_state_t;

endpackage : valve_seq_pkg

`default_nettype wire

// ===== core/valve_src_eval.sv
/*
 * valve_src_eval - evaluates one open source condition.
 * Assumes scaled analog measurements and digital inputs are synchronous.
 * Select codes: 0 none, 1..10 analog channel, 11..14 digital input.
 */
`timescale 1ns/1ps
`default_nettype none
`include "valve_seq_map.svh"

module valve_src_eval (
    // configuration
    input wire logic [3:0] sel_i,
    input wire logic dir_le_i,
    input wire logic [15:0] setpoint_i,
    // process inputs
    input wire logic [159:0] analog_i,
    input wire logic [3:0] digital_i,
    // result
    output logic used_o,
    output logic met_o
);
    logic [15:0] meas;
    logic [3:0] ai_idx;
    logic [1:0] di_idx;

    always_comb begin
        ai_idx = sel_i - 4'h1;
        di_idx = 2'(sel_i - 4'hb);
        meas = analog_i[ai_idx*16 +: 16];
        used_o = (sel_i != 4'h0) && (sel_i < 4'hf);
        met_o = 1'b0;
        if (sel_i >= 4'hb && sel_i < 4'hf) begin
            met_o = digital_i[di_idx];
        end else if (sel_i != 4'h0) begin
            met_o = dir_le_i ? (meas <= setpoint_i)
                             : (meas >= setpoint_i);
        end
    end

endmodule : valve_src_eval

`default_nettype wire

// ===== test/valve_seq_properties.sv
/*
 * valve_seq_properties - port checks of the valve sequencer.
 * Assumes a bind to valve_seq; control and travel are snooped from writes.
 */
`timescale 1ns/1ps
`default_nettype none
`include "valve_seq_map.svh"

module valve_seq_properties (
    // clock, reset, register port
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // process and valve
    input wire logic close_req_i,
    input wire logic [1:0] hand_off_auto_selector_i,
    input wire logic shutdown_fault_active_i,
    input wire logic [1:0] pump_phase_i,
    input wire logic pos_open_i,
    input wire logic pos_closed_i,
    input wire logic valve_open_cmd_o,
    input wire logic valve_fault_o
);
    logic [4:0] ctrl_q;
    logic [15:0] trav_q;
    logic [31:0] since_q;
    logic cmd_q;
    logic ind;
    logic pmp;
    logic cmd;
    logic flt;
    assign ind = ctrl_q[1:0] == 2'h2;
    assign pmp = ctrl_q[1:0] == 2'h1;
    assign cmd = valve_open_cmd_o;
    assign flt = valve_fault_o;
    // cycles since the last command change, saturating
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= 5'h00;
            trav_q <= `VS_TRAVEL_RST_S;
            since_q <= 32'h0000_0000;
            cmd_q <= 1'h0;
        end else begin
            cmd_q <= cmd;
            if (reg_wr_i && reg_addr_i == `VS_ADDR_CTRL) begin
                ctrl_q <= reg_wdata_i[4:0];
            end
            if (reg_wr_i && reg_addr_i == `VS_ADDR_TRAVEL) begin
                trav_q <= reg_wdata_i[15:0];
            end
            if (cmd != cmd_q) begin
                since_q <= 32'h0000_0000;
            end else if (since_q != 32'hffff_ffff) begin
                since_q <= since_q + 32'h0000_0001;
            end
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    chk_read_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside read slot");
    chk_hoa_close: assert property (
        (ind && !ctrl_q[2] && hand_off_auto_selector_i == 2'h0)[*3]
        |-> !cmd) else $error("selector off left valve open");
    chk_sdf_close: assert property (
        (ind && !ctrl_q[3] && shutdown_fault_active_i)[*3] |-> !cmd)
        else $error("shutdown left valve open");
    chk_close_wins: assert property (
        (ind && close_req_i)[*3] |-> !cmd)
        else $error("close request lost to open");
    chk_pump_open: assert property (
        (pmp && pump_phase_i == 2'h1)[*3] |-> cmd)
        else $error("pre-run did not open");
    chk_pump_close: assert property (
        (pmp && pump_phase_i == 2'h3)[*3] |-> !cmd)
        else $error("post-run did not close");
    chk_fault_cause: assert property (
        $rose(flt) |-> ($past(cmd) ? !$past(pos_open_i)
        : !$past(pos_closed_i))) else $error("fault while confirmed");
    chk_travel_early: assert property (
        $rose(flt) |-> 64'(since_q) >= 64'(trav_q) * `VS_CLK_HZ)
        else $error("fault before travel time");
    chk_confirm_clear: assert property (
        ((cmd && pos_open_i) || (!cmd && pos_closed_i))[*2] |-> !flt)
        else $error("fault kept after confirmation");

    cover property ($rose(flt));
    cover property (pmp && pump_phase_i == 2'h1 ##1 cmd);
    cover property (ind && $rose(cmd));
endmodule : valve_seq_properties

`default_nettype wire

// ===== test/valve_actuator_model.sv
/*
 * valve_actuator_model - valve that confirms a position STROKE+2 cycles
 * after each command change; stall_i withholds the confirmation.
 * Assumes it starts closed out of reset.
 */
`timescale 1ns/1ps
`default_nettype none

module valve_actuator_model #(
    parameter int STROKE = 6
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic open_cmd_i,
    input wire logic stall_i,
    output logic pos_open_o,
    output logic pos_closed_o
);
    logic [7:0] cnt_q;
    logic last_q;
    // both confirmations drop while moving
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 8'h00;
            last_q <= 1'h0;
            pos_open_o <= 1'h0;
            pos_closed_o <= 1'h1;
        end else begin
            last_q <= open_cmd_i;
            if (open_cmd_i != last_q) begin
                cnt_q <= 8'h00;
                pos_open_o <= 1'h0;
                pos_closed_o <= 1'h0;
            end else if (cnt_q != 8'(STROKE)) begin
                cnt_q <= cnt_q + 8'h01;
            end else if (!stall_i) begin
                pos_open_o <= open_cmd_i;
                pos_closed_o <= !open_cmd_i;
            end
        end
    end
endmodule : valve_actuator_model

`default_nettype wire

// ===== test/valve_seq_bench.sv
/*
 * valve_seq_bench - directed tests of the valve sequencer.
 * Assumes the actuator model on the valve side and a 20 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "valve_seq_map.svh"

module valve_seq_bench;
    logic clk_sys_i = 1'h0;
    logic nrst_i = 1'h0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'h0;
    logic reg_rd_i = 1'h0;
    logic [31:0] reg_rdata_o;
    logic [159:0] analog_i = 160'h0;
    logic [3:0] digital_i = 4'h0;
    logic close_req_i = 1'h0;
    logic [1:0] hand_off_auto_selector = 2'h0;
    logic sd = 1'h0;
    logic [1:0] pump_phase_i = 2'h0;
    logic stall = 1'h0;
    logic pos_open;
    logic pos_closed;
    logic cmd;
    logic flt;
    logic irq;
    int failures = 0;
    int cmp_count = 0;

    valve_seq i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .analog_i(analog_i), .digital_i(digital_i),
        .close_req_i(close_req_i), .hand_off_auto_selector_i(hand_off_auto_selector),
        .shutdown_fault_active_i(sd), .pump_phase_i(pump_phase_i),
        .pos_open_i(pos_open), .pos_closed_i(pos_closed),
        .valve_open_cmd_o(cmd), .valve_fault_o(flt), .irq_o(irq));
    valve_actuator_model i_valve (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .open_cmd_i(cmd), .stall_i(stall), .pos_open_o(pos_open),
        .pos_closed_o(pos_closed));

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'h0;
        #1;
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'h0;
        #1 check(reg_rdata_o & m, exp);
    endtask : rdchk
    // process inputs, then the command once the decision has settled
    task automatic step(input logic [15:0] a0, input logic [15:0] a1,
        input logic dg, input logic cl, input logic [1:0] h,
        input logic s, input logic exp);
        @(posedge clk_sys_i);
        analog_i <= {128'h0, a1, a0};
        digital_i <= {3'h0, dg};
        close_req_i <= cl;
        hand_off_auto_selector <= h;
        sd <= s;
        repeat (5) @(posedge clk_sys_i);
        #1 check({31'h0, cmd}, {31'h0, exp});
    endtask : step

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_regs();
        rdchk(`VS_ADDR_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rdchk(`VS_ADDR_TRAVEL, 32'h0000_ffff, 32'h0000_001e);
        wr(4'hf, 32'hffff_ffff);
        rdchk(4'hf, 32'hffff_ffff, 32'h0000_0000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_comb();
        wr(`VS_ADDR_SRC_BASE, 32'h0001_0100);
        wr(`VS_ADDR_SRC_BASE + 4'h1, 32'h000b_0000);
        wr(`VS_ADDR_SRC_BASE + 4'h2, 32'h0012_0050);
        wr(`VS_ADDR_SRC_LAST, 32'h0000_0000);
        wr(`VS_ADDR_CTRL, 32'h0000_000e);
        step(16'h00ff, 16'h0050, 1'h1, 1'h0, 2'h2, 1'h0, 1'h0);
        step(16'h0100, 16'h0051, 1'h1, 1'h0, 2'h2, 1'h0, 1'h0);
        step(16'h0100, 16'h0050, 1'h1, 1'h0, 2'h2, 1'h0, 1'h1);
        step(16'h0100, 16'h0050, 1'h1, 1'h1, 2'h2, 1'h0, 1'h0);
        wr(`VS_ADDR_CTRL, 32'h0000_001e);
        step(16'h0000, 16'hffff, 1'h0, 1'h0, 2'h2, 1'h0, 1'h0);
        step(16'h0000, 16'hffff, 1'h1, 1'h0, 2'h2, 1'h0, 1'h1);
        step(16'h0000, 16'hffff, 1'h1, 1'h1, 2'h2, 1'h0, 1'h0);
        $display("test sources done");
    endtask : t_comb
    task automatic t_modes();
        wr(`VS_ADDR_CTRL, 32'h0000_001a);
        step(16'h0000, 16'hffff, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0);
        step(16'h0000, 16'hffff, 1'h1, 1'h0, 2'h1, 1'h0, 1'h1);
        step(16'h0000, 16'hffff, 1'h1, 1'h0, 2'h0, 1'h0, 1'h0);
        wr(`VS_ADDR_CTRL, 32'h0000_001e);
        step(16'h0000, 16'hffff, 1'h1, 1'h0, 2'h0, 1'h0, 1'h1);
        wr(`VS_ADDR_CTRL, 32'h0000_0016);
        step(16'h0000, 16'hffff, 1'h1, 1'h0, 2'h2, 1'h1, 1'h0);
        step(16'h0000, 16'hffff, 1'h1, 1'h0, 2'h2, 1'h0, 1'h1);
        wr(`VS_ADDR_CTRL, 32'h0000_001e);
        step(16'h0000, 16'hffff, 1'h1, 1'h0, 2'h2, 1'h1, 1'h1);
        $display("test selector and shutdown done");
    endtask : t_modes
    task automatic t_pump();
        logic [1:0] ph [5] = '{2'h3, 2'h1, 2'h0, 2'h2, 2'h3};
        logic ex [5] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0};
        wr(`VS_ADDR_CTRL, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_i);
            pump_phase_i <= ph[i];
            step(16'h0000, 16'h0000, 1'h0, 1'h0, 2'h0, 1'h1, ex[i]);
        end
        $display("test pump sequence done");
    endtask : t_pump
    task automatic t_fault();
        int n;
        repeat (10) @(posedge clk_sys_i);
        rdchk(`VS_ADDR_IRQ_STAT, 32'h0000_0006, 32'h0000_0006);
        wr(`VS_ADDR_IRQ_MASK, 32'h0000_0001);
        wr(`VS_ADDR_IRQ_STAT, 32'h0000_0007);
        @(posedge clk_sys_i);
        stall <= 1'h1;
        wr(`VS_ADDR_TRAVEL, 32'h0000_0000);
        wr(`VS_ADDR_CTRL, 32'h0000_001e);
        step(16'h0000, 16'h0000, 1'h1, 1'h0, 2'h2, 1'h0, 1'h1);
        n = 0;
        while (flt !== 1'h1 && n < 40) begin
            @(posedge clk_sys_i);
            n++;
        end
        #1 check({31'h0, flt}, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0001);
        rdchk(`VS_ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
        wr(`VS_ADDR_IRQ_STAT, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0000);
        check({31'h0, cmd}, 32'h0000_0001);
        wr(`VS_ADDR_TRAVEL, 32'h0000_001e);
        @(posedge clk_sys_i);
        stall <= 1'h0;
        repeat (10) @(posedge clk_sys_i);
        #1 check({31'h0, flt}, 32'h0000_0000);
        rdchk(`VS_ADDR_STATUS, 32'h0000_003f, 32'h0000_0022);
        $display("test travel fault done");
    endtask : t_fault

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        forever #25 clk_sys_i = !clk_sys_i;
    end
    initial begin
        #(50 * 20000);
        failures++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'h1;
        t_regs();
        t_comb();
        t_modes();
        t_pump();
        t_fault();
        end_of_test();
    end
endmodule : valve_seq_bench

bind valve_seq valve_seq_properties i_chk (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .close_req_i(close_req_i),
    .hand_off_auto_selector_i(hand_off_auto_selector_i),
    .shutdown_fault_active_i(shutdown_fault_active_i),
    .pump_phase_i(pump_phase_i), .pos_open_i(pos_open_i),
    .pos_closed_i(pos_closed_i), .valve_open_cmd_o(valve_open_cmd_o),
    .valve_fault_o(valve_fault_o));

`default_nettype wire
